// file: dv/swcd_decoder_assertions.sv
// Port checks of the serial write command decoder, bound into every decoder instance.
// Assumes the constants header and package are compiled first; enable is held high.
`timescale 1ns/1ps
`include "swcd_consts.svh"

module swcd_checker (
    input wire logic                      clock,
    input wire logic                      nrst,
    input wire logic                      enable,
    input wire logic [`SWCD_BANK_W-1:0]   bank_sel,
    input wire logic                      pointer_auto_advance,
    input wire logic                      ptr_load,
    input wire logic [`SWCD_PTR_W-1:0]    ptr_load_value,
    input wire logic [`SWCD_ADDR_W-1:0]   reg_rd_addr,
    input wire swcd_pkg::swcd_reg_wr_type reg_wr,
    input wire swcd_pkg::swcd_buf_wr_type buf_wr,
    input wire logic [`SWCD_PTR_W-1:0]    buffer_write_pointer,
    input wire logic                      soft_reset_pulse,
    input wire logic                      frame_active
);
    // Every check samples on the system clock and rests while reset is low.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_ptr_step;
        $rose(buf_wr.valid) && $past(pointer_auto_advance) && !$past(ptr_load)
            |-> buffer_write_pointer == buf_wr.addr + 13'h1;
    endproperty
    a_ptr_step: assert property (p_ptr_step)
        else $error("write pointer did not step by one");
    property p_ptr_hold;
        !$rose(buf_wr.valid) && !$past(ptr_load) |-> $stable(buffer_write_pointer);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold)
        else $error("write pointer moved without a buffer byte");
    property p_ptr_load;
        $past(ptr_load) |-> buffer_write_pointer == $past(ptr_load_value);
    endproperty
    a_ptr_load: assert property (p_ptr_load)
        else $error("write pointer load lost");
    property p_buf_addr;
        $rose(buf_wr.valid) |-> buf_wr.addr == $past(buffer_write_pointer);
    endproperty
    a_buf_addr: assert property (p_buf_addr)
        else $error("buffer byte not stored at the write pointer");
    property p_reg_pulse;
        reg_wr.valid && enable |=> !reg_wr.valid [*8];
    endproperty
    a_reg_pulse: assert property (p_reg_pulse)
        else $error("register write strobe too long or too close");
    property p_buf_pulse;
        buf_wr.valid && enable |=> !buf_wr.valid [*8];
    endproperty
    a_buf_pulse: assert property (p_buf_pulse)
        else $error("buffer write strobe too long or too close");
    property p_framed;
        reg_wr.valid || buf_wr.valid |-> frame_active;
    endproperty
    a_framed: assert property (p_framed)
        else $error("write issued outside a frame");
    property p_reg_fields;
        reg_wr.valid |-> reg_wr.bank == $past(bank_sel) && reg_wr.addr == reg_rd_addr;
    endproperty
    a_reg_fields: assert property (p_reg_fields)
        else $error("register write bank or address wrong");
    property p_soft_reset;
        soft_reset_pulse && enable |-> !frame_active ##1 !soft_reset_pulse;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset pulse inside a frame or too long");

    // Main traffic kinds seen at least once.
    c_reg: cover property (reg_wr.valid);
    c_wrap: cover property (buf_wr.valid && buf_wr.addr == 13'h1fff);
    c_reset: cover property (soft_reset_pulse);
endmodule

bind swcd_decoder swcd_checker u_chk (.clock(clock), .nrst(nrst), .enable(enable), .bank_sel(bank_sel),
    .pointer_auto_advance(pointer_auto_advance), .ptr_load(ptr_load), .ptr_load_value(ptr_load_value),
    .reg_rd_addr(reg_rd_addr), .reg_wr(reg_wr), .buf_wr(buf_wr), .buffer_write_pointer(buffer_write_pointer),
    .soft_reset_pulse(soft_reset_pulse), .frame_active(frame_active));

// file: dv/swcd_host_model.sv
// Host model that drives the serial pins of the write command decoder as a mode 0 master.
// Assumes the 20 MHz system clock is given; all pin changes land 1 ns after its rising edge.
`timescale 1ns/1ps

module swcd_host_model (
    input  wire logic clock,
    output logic      spi_sck,
    output logic      spi_si,
    output logic      spi_cs_n
);
    // Pins start deselected with the serial clock parked low.
    initial begin
        spi_sck = 1'b0;
        spi_si = 1'b0;
        spi_cs_n = 1'b1;
    end

    // Waits a number of system clocks and steps just past the edge.
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Opens a frame by lowering chip-select.
    task automatic select;
        wait_clk(1);
        spi_cs_n = 1'b0;
        wait_clk(4);
    endtask

    // Sends the top n bits of a byte, most significant first, slow enough for the input filter.
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            spi_si = b[i];
            wait_clk(4);
            spi_sck = 1'b1;
            wait_clk(6);
            spi_sck = 1'b0;
        end
    endtask

    // Ends a frame; the released data line shows the inverse so no stale bit looks valid.
    task automatic deselect;
        wait_clk(2);
        spi_cs_n = 1'b1;
        spi_si = ~spi_si;
        wait_clk(8);
    endtask
endmodule

// file: dv/tb_swcd_decoder.sv
// Self-checking bench of the serial write command decoder with a small register file model.
// Assumes the host model drives the serial pins; enable stays high throughout.
`timescale 1ns/1ps
`include "swcd_consts.svh"

module tb_swcd_decoder;
    logic                      clock;
    logic                      nrst;
    logic                      auto_adv;
    logic                      ptr_load;
    logic [1:0]                bank_sel;
    logic [12:0]               ptr_val;
    logic                      sck;
    logic                      si;
    logic                      cs_n;
    logic [4:0]                rd_addr;
    logic [12:0]               wr_ptr;
    logic                      srst;
    logic                      frm_act;
    logic [1:0]                rw_bank;
    swcd_pkg::swcd_reg_wr_type reg_wr;
    swcd_pkg::swcd_buf_wr_type buf_wr;
    swcd_pkg::swcd_buf_wr_type bw_q[$];
    logic [7:0]                rf[32] = '{default: 8'h00};
    int                        rw_cnt, sr_cnt, cyc, err_total, n_compared;

    swcd_host_model host (.clock(clock), .spi_sck(sck), .spi_si(si), .spi_cs_n(cs_n));
    swcd_decoder dut (.clock(clock), .nrst(nrst), .enable(1'b1), .spi_sck(sck), .spi_si(si), .spi_cs_n(cs_n),
        .bank_sel(bank_sel), .pointer_auto_advance(auto_adv), .ptr_load(ptr_load), .ptr_load_value(ptr_val),
        .reg_rd_data(rf[rd_addr]), .reg_rd_addr(rd_addr), .reg_wr(reg_wr), .buf_wr(buf_wr),
        .buffer_write_pointer(wr_ptr), .soft_reset_pulse(srst), .frame_active(frm_act));

    // Clock of 50 ns period.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Register file, buffer log and pulse counts; also the run ceiling.
    always @(posedge clock) begin
        if (reg_wr.valid === 1'b1) begin
            rf[reg_wr.addr] <= reg_wr.data;
            rw_bank <= reg_wr.bank;
            rw_cnt <= rw_cnt + 1;
        end
        if (buf_wr.valid === 1'b1) bw_q.push_back(buf_wr);
        if (srst === 1'b1) sr_cnt <= sr_cnt + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            $display("unexpected at %0t: run timed out", $time);
            end_of_test;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One frame: command byte, then n bits of one data byte.
    task automatic frame(input logic [7:0] c, input logic [7:0] d, input int n);
        host.select;
        host.send(c, 8);
        if (n > 0) host.send(d, n);
        host.deselect;
    endtask

    task automatic t_reg_write;
        host.select;
        host.send({`SWCD_OP_REG_WRITE, 5'h05}, 8);
        host.send(8'ha5, 8);
        chk(16'(frm_act), 16'h1);
        host.send(8'h3c, 8);
        host.deselect;
        chk(16'(frm_act), 16'h0);
        chk(16'(rw_cnt), 16'h2);
        chk(16'(rf[5]), 16'h3c);
        $display("register write done");
    endtask

    task automatic t_abort;
        frame({`SWCD_OP_REG_WRITE, 5'h06}, 8'hff, 5);
        chk(16'(rw_cnt), 16'h2);
        bank_sel = 2'h2;
        frame({`SWCD_OP_REG_WRITE, 5'h06}, 8'h81, 8);
        chk(16'(rf[6]), 16'h81);
        chk(16'(rw_bank), 16'h2);
        frame({`SWCD_OP_BIT_SET, 5'h06}, 8'h0f, 7);
        chk(16'(rf[6]), 16'h81);
        chk(16'(rw_cnt), 16'h3);
        $display("abort done");
    endtask

    task automatic t_set_clear;
        frame({`SWCD_OP_REG_WRITE, 5'h07}, 8'hf1, 8);
        frame({`SWCD_OP_BIT_CLEAR, 5'h07}, 8'h17, 8);
        chk(16'(rf[7]), 16'he0);
        frame({`SWCD_OP_BIT_SET, 5'h07}, 8'h0a, 8);
        chk(16'(rf[7]), 16'hea);
        $display("bit set and clear done");
    endtask

    task automatic t_buffer;
        @(posedge clock) #1;
        ptr_val = 13'h1ffe;
        ptr_load = 1'b1;
        auto_adv = 1'b1;
        @(posedge clock) #1;
        ptr_load = 1'b0;
        host.select;
        for (int i = 0; i < 4; i++) host.send(i == 0 ? {`SWCD_OP_BUF_WRITE, `SWCD_ARG_BUFFER} : 8'(i * 17), 8);
        host.deselect;
        chk(16'(bw_q.size()), 16'h3);
        for (int i = 0; i < 3; i++) begin
            chk(16'(bw_q[i].addr), 16'(13'(13'h1ffe + i)));
            chk(16'(bw_q[i].data), 16'((i + 1) * 17));
        end
        chk(16'(wr_ptr), 16'h0001);
        auto_adv = 1'b0;
        frame({`SWCD_OP_BUF_WRITE, `SWCD_ARG_BUFFER}, 8'h44, 8);
        chk(16'(bw_q[3].addr), 16'h0001);
        chk(16'(wr_ptr), 16'h0001);
        $display("buffer write done");
    endtask

    task automatic t_refused;
        logic [7:0] bad[5] = '{8'h07, 8'h3a, 8'hc7, 8'h7b, 8'hfe};
        foreach (bad[i]) frame(bad[i], 8'h55, 8);
        chk(16'(rw_cnt), 16'h6);
        chk(16'(bw_q.size()), 16'h4);
        chk(16'(sr_cnt), 16'h0);
        chk(16'(rf[7]), 16'hea);
        $display("refused commands done");
    endtask

    task automatic t_soft_reset;
        frame({`SWCD_OP_SOFT_RESET, `SWCD_ARG_RESET}, 8'h00, 0);
        chk(16'(sr_cnt), 16'h1);
        frame({`SWCD_OP_SOFT_RESET, `SWCD_ARG_RESET}, 8'h00, 8);
        chk(16'(sr_cnt), 16'h2);
        $display("soft reset done");
    endtask

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Reset for four clocks, then run every scenario.
    initial begin
        nrst = 1'b0;
        auto_adv = 1'b0;
        ptr_load = 1'b0;
        bank_sel = 2'h1;
        ptr_val = 13'h0000;
        repeat (4) @(posedge clock);
        #1 nrst = 1'b1;
        t_reg_write;
        t_abort;
        t_set_clear;
        t_buffer;
        t_refused;
        t_soft_reset;
        end_of_test;
    end
endmodule

// file: inc/swcd_consts.svh
// Constants of the serial write command decoder: opcodes, arguments, pin indices.
// Assumes inclusion by bare name from the package and the decoder module.
//
// Overview of operation
// - First byte holds a 3-bit opcode over a 5-bit argument.
// - Serial mode 0, clock idles low, input sampled on rising clock edges.
// - Register write is opcode, 5-bit address of 32 in bank, data MSB first.
// - Register write reaches Ethernet, media-access and management groups in any order.
// - Register write data commits on the rising edge completing the data byte.
// - Chip-select rising mid-byte discards that register write byte.
// - Buffer write uses argument 1Ah; bytes stored at the write pointer.
// - With auto-advance set, write pointer steps by one after each byte.
// - With auto-advance set, pointer at top address wraps to zero.
// - Further bytes under held chip-select are stored one after another.
// - Bit set ORs the data byte into the addressed register on last bit.
// - Bit clear ANDs the inverted data byte into the register on last bit.
// - Chip-select rising mid-byte abandons the bit set or clear byte.
// - Soft reset is opcode with argument 1Fh, acted on at chip-select rise.
`ifndef SWCD_CONSTS_SVH
`define SWCD_CONSTS_SVH

// Opcode field values of the first command byte.
`define SWCD_OP_REG_READ     3'h0
`define SWCD_OP_BUF_READ     3'h1
`define SWCD_OP_REG_WRITE    3'h2
`define SWCD_OP_BUF_WRITE    3'h3
`define SWCD_OP_BIT_SET      3'h4
`define SWCD_OP_BIT_CLEAR    3'h5
`define SWCD_OP_SOFT_RESET   3'h7

// Fixed arguments of the buffer and reset commands.
`define SWCD_ARG_BUFFER      5'h1a
`define SWCD_ARG_RESET       5'h1f

// Field layout of the first byte.
`define SWCD_OP_MSB          7
`define SWCD_OP_LSB          5
`define SWCD_ARG_MSB         4
`define SWCD_ARG_LSB         0

// Widths of the datapath.
`define SWCD_ADDR_W          5
`define SWCD_BANK_W          2
`define SWCD_DATA_W          8
`define SWCD_PTR_W           13

// Last bit position within a byte, counted from zero.
`define SWCD_LAST_BIT        3'h7

// Pin indices of the sampled input vector.
`define SWCD_PIN_SI          0
`define SWCD_PIN_SCK         1
`define SWCD_PIN_CS_N        2
`define SWCD_PIN_COUNT       3

`endif

// file: inc/swcd_pkg.sv
// Types of the serial write command decoder.
// Assumes the constants header sits on the include path.
`include "swcd_consts.svh"

package swcd_pkg;

    // Kind of command being executed once the first byte is decoded.
    typedef enum logic [1:0] {
        SWCD_KIND_WRITE = 2'h0,
        SWCD_KIND_BUFFER = 2'h1,
        SWCD_KIND_SET = 2'h2,
        SWCD_KIND_CLEAR = 2'h3
    } swcd_kind_type;

    // Decoder states, one-hot.
    typedef enum logic [4:0] {
        SWCD_ST_IDLE  = 5'h01,
        SWCD_ST_CMD   = 5'h02,
        SWCD_ST_DATA  = 5'h04,
        SWCD_ST_SKIP  = 5'h08,
        SWCD_ST_RESET = 5'h10
    } swcd_state_type;

    // Register write toward the control register file.
    typedef struct packed {
        logic                     valid;
        logic [`SWCD_BANK_W-1:0]  bank;
        logic [`SWCD_ADDR_W-1:0]  addr;
        logic [`SWCD_DATA_W-1:0]  data;
    } swcd_reg_wr_type;

    // Byte write toward the buffer memory.
    typedef struct packed {
        logic                     valid;
        logic [`SWCD_PTR_W-1:0]   addr;
        logic [`SWCD_DATA_W-1:0]  data;
    } swcd_buf_wr_type;

endpackage

// file: logic/swcd_decoder.sv
// Serial write command decoder: register write, buffer write, bit set, bit clear, soft reset.
// Assumes serial pins arrive asynchronously and are oversampled by the 20 MHz system clock;
// the control register file applies register writes and supplies the addressed value.
`timescale 1ns/1ps

`include "swcd_consts.svh"

module swcd_decoder (
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic                        enable,
    input  wire logic                        spi_sck,
    input  wire logic                        spi_si,
    input  wire logic                        spi_cs_n,
    input  wire logic [`SWCD_BANK_W-1:0]     bank_sel,
    input  wire logic                        pointer_auto_advance,
    input  wire logic                        ptr_load,
    input  wire logic [`SWCD_PTR_W-1:0]      ptr_load_value,
    input  wire logic [`SWCD_DATA_W-1:0]     reg_rd_data,
    output logic [`SWCD_ADDR_W-1:0]          reg_rd_addr,
    output swcd_pkg::swcd_reg_wr_type        reg_wr,
    output swcd_pkg::swcd_buf_wr_type        buf_wr,
    output logic [`SWCD_PTR_W-1:0]           buffer_write_pointer,
    output logic                             soft_reset_pulse,
    output logic                             frame_active
);

    // Synchroniser stages and the filtered level of each pin.
    logic [`SWCD_PIN_COUNT-1:0]  pin_s1_reg;
    logic [`SWCD_PIN_COUNT-1:0]  pin_s2_reg;
    logic [`SWCD_PIN_COUNT-1:0]  pin_s3_reg;
    logic [`SWCD_PIN_COUNT-1:0]  pin_lvl_reg;
    logic [`SWCD_PIN_COUNT-1:0]  pin_raw;
    logic [`SWCD_PIN_COUNT-1:0]  pin_agree;

    // Decoder state.
    swcd_pkg::swcd_state_type    state_reg;
    swcd_pkg::swcd_kind_type     kind_reg;
    logic [2:0]                  bit_cnt_reg;
    logic [`SWCD_DATA_W-1:0]     shift_reg;
    logic [`SWCD_DATA_W-1:0]     shift_next;
    logic [`SWCD_PTR_W-1:0]      ptr_reg;

    // Derived events.
    logic                        sck_rise;
    logic                        cs_rise;
    logic                        cs_fall;
    logic                        byte_done;
    logic [2:0]                  opcode;
    logic [`SWCD_ADDR_W-1:0]     argument;
    logic [`SWCD_DATA_W-1:0]     merged_data;

    assign pin_raw = {spi_cs_n, spi_sck, spi_si};

    // Each pin passes three flip-flops; a change is taken once the second and third agree.
    genvar gi;
    generate
        for (gi = 0; gi < `SWCD_PIN_COUNT; gi = gi + 1) begin : g_sync
            assign pin_agree[gi] = (pin_s2_reg[gi] == pin_s3_reg[gi]);

            // Three-stage sampler with agreement filter; chip-select idles high.
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    pin_s1_reg[gi]  <= (gi == `SWCD_PIN_CS_N);
                    pin_s2_reg[gi]  <= (gi == `SWCD_PIN_CS_N);
                    pin_s3_reg[gi]  <= (gi == `SWCD_PIN_CS_N);
                    pin_lvl_reg[gi] <= (gi == `SWCD_PIN_CS_N);
                end else if (enable) begin
                    pin_s1_reg[gi] <= pin_raw[gi];
                    pin_s2_reg[gi] <= pin_s1_reg[gi];
                    pin_s3_reg[gi] <= pin_s2_reg[gi];
                    if (pin_agree[gi]) begin
                        pin_lvl_reg[gi] <= pin_s3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    // Serial clock edges are seen only while selected; data is taken on the rising edge.
    assign sck_rise = enable && pin_agree[`SWCD_PIN_SCK] && pin_s3_reg[`SWCD_PIN_SCK]
                      && !pin_lvl_reg[`SWCD_PIN_SCK] && !pin_lvl_reg[`SWCD_PIN_CS_N];
    assign cs_rise  = enable && pin_agree[`SWCD_PIN_CS_N] && pin_s3_reg[`SWCD_PIN_CS_N]
                      && !pin_lvl_reg[`SWCD_PIN_CS_N];
    assign cs_fall  = enable && pin_agree[`SWCD_PIN_CS_N] && !pin_s3_reg[`SWCD_PIN_CS_N]
                      && pin_lvl_reg[`SWCD_PIN_CS_N];

    // Bytes arrive most significant bit first, so each new bit enters at the bottom.
    assign shift_next = {shift_reg[`SWCD_DATA_W-2:0], pin_s3_reg[`SWCD_PIN_SI]};
    assign byte_done  = sck_rise && (bit_cnt_reg == `SWCD_LAST_BIT) && !cs_rise;
    assign opcode     = shift_next[`SWCD_OP_MSB:`SWCD_OP_LSB];
    assign argument   = shift_next[`SWCD_ARG_MSB:`SWCD_ARG_LSB];

    // New register value: plain write, OR for bit set, AND with the inverse for bit clear.
    always_comb begin
        case (kind_reg)
            swcd_pkg::SWCD_KIND_SET:   merged_data = reg_rd_data | shift_next;
            swcd_pkg::SWCD_KIND_CLEAR: merged_data = reg_rd_data & ~shift_next;
            default:                   merged_data = shift_next;
        endcase
    end

    // Bit counter and shifter; both restart whenever chip-select is high, dropping partial bytes.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_reg <= 3'h0;
            shift_reg   <= 8'h00;
        end else if (enable) begin
            if (pin_lvl_reg[`SWCD_PIN_CS_N] || cs_rise) begin
                bit_cnt_reg <= 3'h0;
                shift_reg   <= 8'h00;
            end else if (sck_rise) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                shift_reg   <= shift_next;
            end
        end
    end

    // Command sequencer: decodes the first byte and then routes each following byte.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg   <= swcd_pkg::SWCD_ST_IDLE;
            kind_reg    <= swcd_pkg::SWCD_KIND_WRITE;
            reg_rd_addr <= 5'h00;
        end else if (enable) begin
            case (state_reg)
                swcd_pkg::SWCD_ST_IDLE: begin
                    if (cs_fall) begin
                        state_reg <= swcd_pkg::SWCD_ST_CMD;
                    end
                end
                swcd_pkg::SWCD_ST_CMD: begin
                    if (cs_rise) begin
                        state_reg <= swcd_pkg::SWCD_ST_IDLE;
                    end else if (byte_done) begin
                        reg_rd_addr <= argument;
                        case (opcode)
                            `SWCD_OP_REG_WRITE: begin
                                kind_reg  <= swcd_pkg::SWCD_KIND_WRITE;
                                state_reg <= swcd_pkg::SWCD_ST_DATA;
                            end
                            `SWCD_OP_BUF_WRITE: begin
                                kind_reg  <= swcd_pkg::SWCD_KIND_BUFFER;
                                state_reg <= (argument == `SWCD_ARG_BUFFER) ? swcd_pkg::SWCD_ST_DATA
                                                                             : swcd_pkg::SWCD_ST_SKIP;
                            end
                            `SWCD_OP_BIT_SET: begin
                                kind_reg  <= swcd_pkg::SWCD_KIND_SET;
                                state_reg <= swcd_pkg::SWCD_ST_DATA;
                            end
                            `SWCD_OP_BIT_CLEAR: begin
                                kind_reg  <= swcd_pkg::SWCD_KIND_CLEAR;
                                state_reg <= swcd_pkg::SWCD_ST_DATA;
                            end
                            `SWCD_OP_SOFT_RESET: begin
                                state_reg <= (argument == `SWCD_ARG_RESET) ? swcd_pkg::SWCD_ST_RESET
                                                                            : swcd_pkg::SWCD_ST_SKIP;
                            end
                            default: begin
                                state_reg <= swcd_pkg::SWCD_ST_SKIP;
                            end
                        endcase
                    end
                end
                swcd_pkg::SWCD_ST_DATA,
                swcd_pkg::SWCD_ST_SKIP,
                swcd_pkg::SWCD_ST_RESET: begin
                    if (cs_rise) begin
                        state_reg <= swcd_pkg::SWCD_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= swcd_pkg::SWCD_ST_IDLE;
                end
            endcase
        end
    end

    // Register writes, set and clear commit when the last data bit of a byte is taken.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_wr <= '0;
        end else if (enable) begin
            reg_wr.valid <= 1'b0;
            if (byte_done && (state_reg == swcd_pkg::SWCD_ST_DATA)
                && (kind_reg != swcd_pkg::SWCD_KIND_BUFFER)) begin
                reg_wr.valid <= 1'b1;
                reg_wr.bank  <= bank_sel;
                reg_wr.addr  <= reg_rd_addr;
                reg_wr.data  <= merged_data;
            end
        end
    end

    // Buffer byte writes, one per completed byte while selected.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            buf_wr <= '0;
        end else if (enable) begin
            buf_wr.valid <= 1'b0;
            if (byte_done && (state_reg == swcd_pkg::SWCD_ST_DATA)
                && (kind_reg == swcd_pkg::SWCD_KIND_BUFFER)) begin
                buf_wr.valid <= 1'b1;
                buf_wr.addr  <= ptr_reg;
                buf_wr.data  <= shift_next;
            end
        end
    end

    // Write pointer: a load from the register file wins over an advance in the same cycle.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ptr_reg <= 13'h0000;
        end else if (enable) begin
            if (ptr_load) begin
                ptr_reg <= ptr_load_value;
            end else if (byte_done && (state_reg == swcd_pkg::SWCD_ST_DATA)
                         && (kind_reg == swcd_pkg::SWCD_KIND_BUFFER) && pointer_auto_advance) begin
                ptr_reg <= ptr_reg + 13'h0001;
            end
        end
    end

    assign buffer_write_pointer = ptr_reg;

    // Soft reset request fires when chip-select rises after a complete reset byte.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            soft_reset_pulse <= 1'b0;
        end else if (enable) begin
            soft_reset_pulse <= cs_rise && (state_reg == swcd_pkg::SWCD_ST_RESET);
        end
    end

    // Frame indicator follows the filtered chip-select level.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            frame_active <= 1'b0;
        end else if (enable) begin
            frame_active <= !pin_lvl_reg[`SWCD_PIN_CS_N] && !cs_rise;
        end
    end

endmodule
